// File: rtl/port_pkg.sv
// Purpose: shared constants and types for the two-pin port block
// Assumes: byte-wide register port with low 16 address bits
// Notes: interrupt registers sit at offsets picked next to the port
package port_pkg;
	localparam logic [15:0] ADDR_DIRECTION = 16'hFFCD;
	localparam logic [15:0] ADDR_OUTPUT_DATA = 16'hFFCF;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFFE0;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hFFE1;
	localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hFFE2;
	localparam logic [15:0] ADDR_MODE = 16'hFFE3;
	localparam logic [7:0] DIRECTION_RESET = 8'hE0;
	localparam logic [7:0] OUTPUT_DATA_RESET = 8'hE0;
	localparam logic [7:0] RESERVED_ONES = 8'hE0;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [2:0] STORE_ONLY_MASK = 3'h7;
	localparam int PIN0 = 0;
	localparam int PIN1 = 1;
	localparam int STORE_LO = 2;
	localparam int STORE_HI = 4;
	localparam int RES_LO = 5;
	localparam int RES_HI = 7;
	localparam logic [2:0] MODE_RESET = 3'h7;
	localparam int MODE_W = 3;
	localparam logic [1:0] PIN_ZERO = 2'h0;
	typedef enum logic [2:0] {
		MODE_1 = 3'h1,
		MODE_3 = 3'h3,
		MODE_5 = 3'h5,
		MODE_6 = 3'h6,
		MODE_7 = 3'h7
	} op_mode_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} reg_req_t;
	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} pin_drive_t;
	// true when pin 1 may only be an input
	function automatic logic pin1_input_only(input logic [2:0] mode);
		pin1_input_only = (mode == MODE_1) || (mode == MODE_3) ||
			(mode == MODE_5);
	endfunction : pin1_input_only
endpackage : port_pkg

// File: rtl/edge_events.sv
// Purpose: catches falling edges on the two request levels
// Assumes: inputs already synchronous to ref_clk
// Notes: requests are active low, so a falling edge is the event
`timescale 1ns/1ps
module edge_events
	import port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [1:0] level,
	output logic [1:0] fall
);
	logic [1:0] last;
	assign fall = last & ~level;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			last <= PIN_ZERO;
		end else begin
			last <= level;
		end
	end
endmodule : edge_events

// File: rtl/two_bit_port_with_irq_inputs.sv
// Purpose: two-pin general purpose port whose pins feed two requests
// Assumes: pin inputs synchronous; hw_standby acts like reset on direction and data
// Notes: sw_standby only freezes the direction and data registers; pins keep driving
// Notes on behaviour
// RQ1 - write-only 8-bit direction register; one makes a pin output
// RQ2 - direction loads E0 on reset and hardware standby, holds in sw standby
// RQ3 - output pins keep driving their level during software standby
// RQ4 - output data register bits 1 and 0 drive output pins
// RQ5 - reading an output pin returns the stored data bit
// RQ6 - reading an input pin returns the sampled pin level, except pin 1 set output in modes 1, 3, 5 reads the stored bit
// RQ7 - data bits 7 to 5 ignore writes and read as one
// RQ8 - data bits 4 to 2 are storage, read when direction one, else one
// RQ9 - data register loads E0 on reset and hardware standby, holds in standby
// RQ10 - pin 0 is input or output and always feeds request 0
// RQ11 - pin 1 is input only in modes 1, 3, 5; setting it output illegal
// RQ12 - pin 1 is input or output in modes 6, 7; always feeds request 1
// RQ13 - direction bits 7 to 2 drive nothing; direction reads give ones
`timescale 1ns/1ps
module two_bit_port_with_irq_inputs
	import port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe,
	output logic [1:0] external_interrupt_request,
	output logic irq
);
	reg_req_t req;
	pin_drive_t drive;
	logic [7:0] port_direction_select;
	logic [7:0] port_output_data;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [MODE_W-1:0] op_mode;
	logic [1:0] req_fall;
	logic [7:0] next_rdata;
	logic [7:0] data_view;
	logic [7:0] next_direction;
	logic [7:0] next_output_data;
	logic [1:0] next_status;
	logic [1:0] next_enable;
	logic [MODE_W-1:0] next_mode;
	logic [1:0] next_request;
	logic [1:0] pin_dir;
	logic [1:0] level;
	logic hit_dir, hit_data, hit_stat, hit_en, hit_clr, hit_mode;
	logic frozen;

	assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write,
		read: reg_read};
	assign frozen = sw_standby;
	assign hit_dir = req.addr == ADDR_DIRECTION;
	assign hit_data = req.addr == ADDR_OUTPUT_DATA;
	assign hit_stat = req.addr == ADDR_IRQ_STATUS;
	assign hit_en = req.addr == ADDR_IRQ_ENABLE;
	assign hit_clr = req.addr == ADDR_IRQ_CLEAR;
	assign hit_mode = req.addr == ADDR_MODE;

	// only bits 1 and 0 reach pins; bits 4 to 2 steer the data read view, bits 7 to 5 are dead storage [RQ13]
	assign pin_dir[PIN0] = port_direction_select[PIN0]; // [RQ10]
	// the illegal pin 1 output setting is held off the pin to avoid
	// a fight with the bus driving it in those modes [RQ11]
	assign pin_dir[PIN1] = port_direction_select[PIN1] &
		~pin1_input_only(op_mode); // [RQ12]
	assign drive.oe = pin_dir; // [RQ1]
	assign drive.out = port_output_data[PIN1:PIN0] & pin_dir; // [RQ4]

	// both requests follow the pin level whatever the direction
	assign level[PIN0] = pin_dir[PIN0] ?
		port_output_data[PIN0] : pin_in[PIN0]; // [RQ10]
	assign level[PIN1] = pin_dir[PIN1] ?
		port_output_data[PIN1] : pin_in[PIN1]; // [RQ12]
	assign next_request = level;

	// read view of the data register
	assign data_view[RES_HI:RES_LO] = RESERVED_ONES[RES_HI:RES_LO]; // [RQ7]
	assign data_view[STORE_HI:STORE_LO] =
		port_output_data[STORE_HI:STORE_LO] |
		~port_direction_select[STORE_HI:STORE_LO]; // [RQ8]
	assign data_view[PIN1] = port_direction_select[PIN1] ?
		port_output_data[PIN1] : pin_in[PIN1]; // [RQ5] [RQ6]
	assign data_view[PIN0] = port_direction_select[PIN0] ?
		port_output_data[PIN0] : pin_in[PIN0]; // [RQ5] [RQ6]

	assign next_rdata = !req.read ? BYTE_ZERO :
		hit_dir ? ALL_ONES : // [RQ13]
		hit_data ? data_view :
		hit_stat ? {6'h00, irq_status} :
		hit_en ? {6'h00, irq_enable} :
		hit_mode ? {5'h00, op_mode} :
		BYTE_ZERO;

	// software standby holds the direction and output data registers [RQ2] [RQ9]
	assign next_direction = (req.write && hit_dir && !frozen) ?
		req.wdata : port_direction_select; // [RQ1]
	assign next_output_data = (req.write && hit_data && !frozen) ?
		{RESERVED_ONES[RES_HI:RES_LO],
		req.wdata[STORE_HI:STORE_LO] & STORE_ONLY_MASK,
		req.wdata[PIN1:PIN0]} :
		port_output_data; // [RQ7] [RQ8]
	// a new event wins over a clear in the same cycle
	assign next_status = (irq_status &
		~((req.write && hit_clr) ? req.wdata[PIN1:PIN0] : PIN_ZERO)) |
		req_fall;
	assign next_enable = (req.write && hit_en) ?
		req.wdata[PIN1:PIN0] : irq_enable;
	assign next_mode = (req.write && hit_mode) ?
		req.wdata[MODE_W-1:0] : op_mode;

	edge_events u_edges (
		.ref_clk(ref_clk),
		.reset(reset),
		.level(level),
		.fall(req_fall)
	);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			port_direction_select <= DIRECTION_RESET;
			port_output_data <= OUTPUT_DATA_RESET;
		end else if (hw_standby) begin
			port_direction_select <= DIRECTION_RESET; // [RQ2]
			port_output_data <= OUTPUT_DATA_RESET; // [RQ9]
		end else begin
			port_direction_select <= next_direction;
			port_output_data <= next_output_data;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_status <= PIN_ZERO;
			irq_enable <= PIN_ZERO;
			op_mode <= MODE_RESET;
		end else begin
			irq_status <= next_status;
			irq_enable <= next_enable;
			op_mode <= next_mode;
		end
	end

	// pins stay driven in software standby since nothing here
	// looks at sw_standby on the drive path [RQ3]
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_out <= PIN_ZERO;
			pin_oe <= PIN_ZERO;
			reg_rdata <= BYTE_ZERO;
			external_interrupt_request <= PIN_ZERO;
			irq <= 1'b0;
		end else begin
			pin_out <= drive.out; // [RQ3] [RQ4]
			pin_oe <= drive.oe;
			reg_rdata <= next_rdata;
			external_interrupt_request <= next_request; // [RQ10] [RQ12]
			irq <= |(next_status & next_enable);
		end
	end
endmodule : two_bit_port_with_irq_inputs

// File: tb/board_pins.sv
// Purpose: board side of the two port pins
// Assumes: no pull resistors; the bench sets the undriven level
// Notes: a driven pin reads back its own level
`timescale 1ns/1ps
module board_pins (
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] ext,
	output wire logic [1:0] pin_lvl
);
	assign pin_lvl = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : board_pins

// File: tb/port_checker.sv
// Purpose: port-level checks for the two-pin port
// Assumes: pin_in carries the resolved wire level
// Notes: mode is tracked from register writes
`timescale 1ns/1ps
module port_checker
	import port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] pin_in,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] external_interrupt_request
);
	logic [2:0] mode_seen;
	wire logic rd_dat = reg_read && reg_addr == ADDR_OUTPUT_DATA;
	wire logic in_only = mode_seen inside {3'h1, 3'h3, 3'h5};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			mode_seen <= MODE_RESET;
		else if (reg_write && reg_addr == ADDR_MODE)
			mode_seen <= reg_wdata[2:0];
	end
	a_dir_reads_ones: assert property (
		reg_read && reg_addr == ADDR_DIRECTION |=> reg_rdata == 8'hFF)
		else $error("direction read not all ones");
	a_reserved_ones: assert property (
		rd_dat |=> reg_rdata[7:5] == 3'h7) else $error("reserved bits");
	a_hw_inputs: assert property (
		hw_standby |-> ##2 pin_oe == 2'h0) else $error("hw standby oe");
	a_sw_hold: assert property (
		(sw_standby && !hw_standby)[*2] |=> $stable(pin_oe[0])
		&& $stable(pin_out[0])) else $error("sw standby drive");
	a_req_follow: assert property (
		!$past(reset) && !pin_oe[0] |->
		external_interrupt_request[0] == $past(pin_in[0]))
		else $error("request 0 level");
	a_pin1_input: assert property (
		in_only && $past(in_only) |-> !pin_oe[1]) else $error("pin 1 oe");
	a_out_read: assert property (
		rd_dat ##1 pin_oe[0] |-> reg_rdata[0] == pin_out[0])
		else $error("output read");
	a_in_read: assert property (
		rd_dat ##1 !pin_oe[0] |-> reg_rdata[0] == $past(pin_in[0]))
		else $error("input read");
endmodule : port_checker
bind two_bit_port_with_irq_inputs port_checker u_port_checker (.*);

// File: tb/tb.sv
// Purpose: self-checking bench for the two-pin port
// Assumes: pins see the resolved wire level
// Notes: waits are fixed counts from the register timing
`timescale 1ns/1ps
module tb
	import port_pkg::*;
;
	logic ref_clk = 0, reset = 1, hw_standby = 0, sw_standby = 0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic reg_write = 0, reg_read = 0, irq;
	logic [1:0] ext = 2'h2, pin_lvl, pin_out, pin_oe, req;
	logic [2:0] modes [5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
	int n_mismatch = 0, samples_checked = 0;
	logic [7:0] exp_oe;
	always #20 ref_clk = ~ref_clk;
	two_bit_port_with_irq_inputs u_two_bit_port_with_irq_inputs (.ref_clk,
		.reset, .hw_standby, .sw_standby, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .pin_in(pin_lvl), .pin_out, .pin_oe,
		.external_interrupt_request(req), .irq);
	board_pins u_board_pins (.pin_out, .pin_oe, .ext, .pin_lvl);
	task chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_write <= 0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 0;
		@(negedge ref_clk);
		chk(reg_rdata, e);
	endtask : rd
	task settle;
		repeat (2) @(negedge ref_clk);
	endtask : settle
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 0;
		rd(ADDR_DIRECTION, 8'hFF);
		rd(ADDR_OUTPUT_DATA, 8'hFE);
		rd(16'hFF00, 8'h00);
		$display("reset test done");
		wr(ADDR_DIRECTION, 8'h1F);
		wr(ADDR_OUTPUT_DATA, 8'h15);
		settle;
		chk({pin_oe, pin_out, 4'h0}, 8'hD0);
		rd(ADDR_OUTPUT_DATA, 8'hF5);
		@(posedge ref_clk);
		sw_standby <= 1;
		wr(ADDR_DIRECTION, 8'h00);
		wr(ADDR_OUTPUT_DATA, 8'h02);
		settle;
		chk({pin_oe, pin_out, 4'h0}, 8'hD0);
		@(posedge ref_clk);
		sw_standby <= 0;
		foreach (modes[i]) begin
			wr(ADDR_MODE, {5'h00, modes[i]});
			settle;
			exp_oe = (modes[i] inside {3'h1, 3'h3, 3'h5}) ? 8'h01 : 8'h03;
			chk({6'h00, pin_oe}, exp_oe);
		end
		$display("output test done");
		wr(ADDR_DIRECTION, 8'h00);
		ext <= 2'h1;
		settle;
		rd(ADDR_OUTPUT_DATA, 8'hFD);
		chk({6'h00, req}, 8'h01);
		// clear events left by earlier pin traffic before the irq test
		wr(ADDR_IRQ_CLEAR, 8'h03);
		ext <= 2'h0;
		settle;
		rd(ADDR_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		settle;
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		settle;
		chk({7'h00, irq}, 8'h00);
		$display("input test done");
		wr(ADDR_DIRECTION, 8'h03);
		hw_standby <= 1;
		settle;
		@(posedge ref_clk);
		hw_standby <= 0;
		settle;
		chk({6'h00, pin_oe}, 8'h00);
		rd(ADDR_OUTPUT_DATA, 8'hFC);
		$display("standby test done");
		give_verdict;
	end
endmodule : tb
